// File: hdl/cgms_pkg.sv
/*
 Constants and types of the clock generator mode sequencer.
 Assumes a 10 MHz bus clock and a classic Wishbone register port.
*/
package cgms_pkg;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [3:0] OFF_CTRL_ONE = 4'h0;
    localparam logic [3:0] OFF_CTRL_TWO = 4'h4;
    localparam logic [3:0] OFF_STATUS = 4'h8;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int C1_SRC_SEL_LO = 6;
    localparam int C1_REF_DIV_LO = 3;
    localparam int C1_IREF = 2;
    localparam int C2_OUT_DIV_LO = 6;
    localparam int C2_RANGE = 5;
    localparam int C2_HIGH_GAIN = 4;
    localparam int C2_LOW_POWER = 3;
    localparam int C2_XTAL_SEL = 2;
    localparam int C2_EXT_CLK_EN = 1;
    localparam int ST_IREF = 4;
    localparam int ST_SRC_LO = 2;
    localparam int ST_OSC = 1;

    // ---------------------------------------------------------------
    // Clock source codes
    // ---------------------------------------------------------------
    localparam logic [1:0] SRC_LOOP = 2'h0;
    localparam logic [1:0] SRC_INT = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;
    localparam logic [1:0] SRC_RSVD = 2'h3;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_CTRL_ONE = 8'h04;
    localparam logic [7:0] RST_CTRL_TWO = 8'h00;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int SWITCH_TIME_NS = 1000;
    localparam int SWITCH_CYCLES = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SWITCH_LAST = 4'(SWITCH_CYCLES - 1);

    // ---------------------------------------------------------------
    // Operating modes
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        internal_ref_locked_mode,
        external_ref_locked_mode,
        internal_bypass_mode,
        external_bypass_mode,
        low_power_bypass_mode
    } cgms_mode_t;

endpackage : cgms_pkg

// File: hdl/cgms_top.sv
/*
 Clock generator mode sequencer: control, status and mode tracking.
 Assumes a classic Wishbone master and a crystal oscillator whose
 stable indication is synchronous to clk.
*/
// Operation
// R1 - Bits 7:6 of control two set output divider; 00 divides by one.
// R2 - Bit 5 of control two selects the high frequency oscillator range.
// R3 - Bit 4 of control two selects high-gain oscillator operation.
// R4 - Bit 2 of control two set selects a crystal as external reference.
// R5 - External reference clock stays active while bit 1 of control two set.
// R6 - Status bit 1 sets once the selected crystal has initialized.
// R7 - Bits 7:6 of control one select clock source; 10 is external reference.
// R8 - Bits 5:3 of control one are reference divider; 111 divides by 128.
// R9 - Software keeps loop reference within 31.25 to 39.0625 kHz.
// R10 - Bit 2 of control one cleared selects external reference source.
// R11 - Status bit 4 shows reference in use; zero means external.
// R12 - Status bits 3:2 show active clock source; 10 means external.
// R13 - Low-power bit in external bypass mode disables both loops.
// R14 - Reset enters internal-reference locked-loop mode.
// R15 - Software follows the eight-step mode change order.
// R16 - Software does nothing between source select and low-power write.
// R17 - Software enters low-power bypass at once when reference too fast.
// R18 - Clock source select 00 selects the loop output.
// R19 - Status fields update only after the new source is switched in.
`timescale 1ns/1ps
module cgms_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic osc_stable,
    output logic osc_enable,
    output logic osc_high_range,
    output logic osc_high_gain,
    output logic osc_crystal_sel,
    output logic osc_ready_flag,
    output logic [1:0] output_divider,
    output logic [2:0] reference_divider,
    output logic [1:0] generator_source,
    output logic fll_enable,
    output logic pll_enable,
    output cgms_pkg::cgms_mode_t mode
);
    import cgms_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl_one;
        logic [7:0] ctrl_two;
        logic ref_status;
        logic [1:0] clk_status;
        logic osc_ready;
        logic osc_on;
        logic [3:0] switch_cnt;
        cgms_mode_t mode;
        logic fll_on;
        logic pll_on;
        logic ack;
        logic [31:0] rdata;
    } cgms_state_t;

    cgms_state_t st;
    cgms_state_t next_st;

    logic req;
    logic want_ref;
    logic [1:0] want_clk;
    logic need_ext;
    logic ext_ok;
    logic clk_diff;
    logic pending;

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    function automatic logic cgms_hit(input logic [3:0] adr, input logic [3:0] off);
        cgms_hit = (adr[3:2] == off[3:2]);
    endfunction : cgms_hit

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        req = wb_cyc_i & wb_stb_i & ~st.ack;
        next_st.ack = req;

        // Register writes take effect at the edge that raises ack
        if (req && wb_we_i && wb_sel_i[0])
        begin
            if (cgms_hit(wb_adr_i, OFF_CTRL_ONE))
            begin
                next_st.ctrl_one = wb_dat_i[7:0]; // R7 R8 R10
            end
            if (cgms_hit(wb_adr_i, OFF_CTRL_TWO))
            begin
                next_st.ctrl_two = wb_dat_i[7:0]; // R1 R2 R3 R4 R13
            end
        end

        // Read data, unmapped reads return zero
        next_st.rdata = 32'h0000_0000;
        if (req && !wb_we_i)
        begin
            if (cgms_hit(wb_adr_i, OFF_CTRL_ONE))
            begin
                next_st.rdata[7:0] = st.ctrl_one;
            end
            if (cgms_hit(wb_adr_i, OFF_CTRL_TWO))
            begin
                next_st.rdata[7:0] = st.ctrl_two;
            end
            if (cgms_hit(wb_adr_i, OFF_STATUS))
            begin
                next_st.rdata[ST_IREF] = st.ref_status; // R11
                next_st.rdata[ST_SRC_LO+:2] = st.clk_status; // R12
                next_st.rdata[ST_OSC] = st.osc_ready; // R6
            end
        end

        // Oscillator control
        want_ref = next_st.ctrl_one[C1_IREF];
        want_clk = next_st.ctrl_one[C1_SRC_SEL_LO+:2];
        next_st.osc_on = next_st.ctrl_two[C2_EXT_CLK_EN] | ~want_ref
            | (want_clk == SRC_EXT); // R5
        next_st.osc_ready = st.osc_on & next_st.osc_on
            & (st.osc_ready | osc_stable); // R6

        // Source switching, status follows only once switched in
        need_ext = ~want_ref | (want_clk == SRC_EXT); // R10
        ext_ok = ~st.ctrl_two[C2_XTAL_SEL] | st.osc_ready; // R4
        clk_diff = (want_clk != SRC_RSVD) && (want_clk != st.clk_status);
        pending = (want_ref != st.ref_status) | clk_diff;
        if (pending && (ext_ok || !need_ext))
        begin
            if (st.switch_cnt == SWITCH_LAST)
            begin
                next_st.switch_cnt = 4'h0;
                next_st.ref_status = want_ref; // R19 R11
                if (clk_diff)
                begin
                    next_st.clk_status = want_clk; // R19 R12 R7
                end
            end
            else
            begin
                next_st.switch_cnt = st.switch_cnt + 4'h1;
            end
        end
        else
        begin
            next_st.switch_cnt = 4'h0;
        end

        // Mode from the sources actually in use
        unique case (next_st.clk_status)
            SRC_LOOP:
            begin
                next_st.mode = next_st.ref_status ? internal_ref_locked_mode
                    : external_ref_locked_mode; // R18
            end
            SRC_INT:
            begin
                next_st.mode = internal_bypass_mode;
            end
            SRC_EXT:
            begin
                next_st.mode = next_st.ctrl_two[C2_LOW_POWER] ? low_power_bypass_mode
                    : external_bypass_mode; // R13
            end
            default:
            begin
                next_st.mode = st.mode;
            end
        endcase
        next_st.fll_on = (next_st.mode != low_power_bypass_mode); // R13
        next_st.pll_on = 1'b0; // R13
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= '{
                ctrl_one: RST_CTRL_ONE,
                ctrl_two: RST_CTRL_TWO,
                ref_status: 1'b1,
                clk_status: SRC_LOOP,
                osc_ready: 1'b0,
                osc_on: 1'b0,
                switch_cnt: 4'h0,
                mode: internal_ref_locked_mode,
                fll_on: 1'b1,
                pll_on: 1'b0,
                ack: 1'b0,
                rdata: 32'h0000_0000
            }; // R14
        end
        else
        begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign wb_dat_o = st.rdata;
    assign wb_ack_o = st.ack;
    assign osc_enable = st.osc_on; // R5
    assign osc_high_range = st.ctrl_two[C2_RANGE]; // R2
    assign osc_high_gain = st.ctrl_two[C2_HIGH_GAIN]; // R3
    assign osc_crystal_sel = st.ctrl_two[C2_XTAL_SEL]; // R4
    assign osc_ready_flag = st.osc_ready;
    assign output_divider = st.ctrl_two[C2_OUT_DIV_LO+:2]; // R1
    assign reference_divider = st.ctrl_one[C1_REF_DIV_LO+:3]; // R8
    assign generator_source = st.clk_status; // R12
    assign fll_enable = st.fll_on;
    assign pll_enable = st.pll_on;
    assign mode = st.mode;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_ack_one_cycle: assert property (@(posedge clk) disable iff (!nrst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_ack_latency: assert property (@(posedge clk) disable iff (!nrst)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("ack not given one cycle after request");

    a_divider_write: assert property (@(posedge clk) disable iff (!nrst) // R1
        (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
            && wb_adr_i[3:2] == OFF_CTRL_TWO[3:2])
        |=> output_divider == $past(wb_dat_i[7:6])
            && osc_high_gain == $past(wb_dat_i[4]))
        else $error("control two write not applied");

    a_ext_clock_on: assert property (@(posedge clk) disable iff (!nrst) // R5
        st.ctrl_two[C2_EXT_CLK_EN] |-> osc_enable)
        else $error("external reference off while enabled");

    a_osc_ready_cause: assert property (@(posedge clk) disable iff (!nrst) // R6
        $rose(osc_ready_flag) |-> $past(osc_stable) && $past(osc_enable))
        else $error("oscillator flag set without stable crystal");

    a_status_switch_time: assert property (@(posedge clk) disable iff (!nrst) // R19
        $changed(generator_source) |-> $past(st.switch_cnt) == SWITCH_LAST)
        else $error("clock status changed before switch time");

    a_ref_needs_osc: assert property (@(posedge clk) disable iff (!nrst) // R11
        $fell(st.ref_status) |-> $past(ext_ok))
        else $error("external reference used before crystal ready");

    a_low_power_loops: assert property (@(posedge clk) disable iff (!nrst) // R13
        (generator_source == SRC_EXT && st.ctrl_two[C2_LOW_POWER])
        |-> mode == low_power_bypass_mode && !fll_enable && !pll_enable)
        else $error("low-power bypass not entered");

    a_reset_mode: assert property (@(posedge clk) disable iff (!nrst) // R14
        !$past(nrst) |-> mode == internal_ref_locked_mode && st.ref_status
            && generator_source == SRC_LOOP)
        else $error("reset did not enter internal locked mode");

    a_loop_source: assert property (@(posedge clk) disable iff (!nrst) // R18
        (generator_source == SRC_LOOP)
        |-> (mode == internal_ref_locked_mode || mode == external_ref_locked_mode))
        else $error("loop source with bypass mode");

    a_range_write: assert property (@(posedge clk) disable iff (!nrst) // R2
        (req && wb_we_i && wb_sel_i[0] && cgms_hit(wb_adr_i, OFF_CTRL_TWO))
        |=> osc_high_range == $past(wb_dat_i[C2_RANGE]))
        else $error("range select write not applied");

    a_xtal_sel_write: assert property (@(posedge clk) disable iff (!nrst) // R4
        (req && wb_we_i && wb_sel_i[0] && cgms_hit(wb_adr_i, OFF_CTRL_TWO))
        |=> osc_crystal_sel == $past(wb_dat_i[C2_XTAL_SEL]))
        else $error("reference type write not applied");

    a_src_sel_write: assert property (@(posedge clk) disable iff (!nrst) // R7
        (req && wb_we_i && wb_sel_i[0] && cgms_hit(wb_adr_i, OFF_CTRL_ONE))
        |=> st.ctrl_one[C1_SRC_SEL_LO+:2] == $past(wb_dat_i[C1_SRC_SEL_LO+:2]))
        else $error("source select write not applied");

    a_ref_div_write: assert property (@(posedge clk) disable iff (!nrst) // R8
        (req && wb_we_i && wb_sel_i[0] && cgms_hit(wb_adr_i, OFF_CTRL_ONE))
        |=> reference_divider == $past(wb_dat_i[C1_REF_DIV_LO+:3]))
        else $error("reference divider write not applied");

    a_ref_sel_write: assert property (@(posedge clk) disable iff (!nrst) // R10
        (req && wb_we_i && wb_sel_i[0] && cgms_hit(wb_adr_i, OFF_CTRL_ONE))
        |=> st.ctrl_one[C1_IREF] == $past(wb_dat_i[C1_IREF]))
        else $error("reference select write not applied");

    a_ref_status_read: assert property (@(posedge clk) disable iff (!nrst) // R11
        (req && !wb_we_i && cgms_hit(wb_adr_i, OFF_STATUS))
        |=> wb_dat_o[ST_IREF] == $past(st.ref_status))
        else $error("reference status read wrong");

    a_clk_status_read: assert property (@(posedge clk) disable iff (!nrst) // R12
        (req && !wb_we_i && cgms_hit(wb_adr_i, OFF_STATUS))
        |=> wb_dat_o[ST_SRC_LO+:2] == $past(generator_source))
        else $error("clock status read wrong");

    a_osc_flag_read: assert property (@(posedge clk) disable iff (!nrst) // R6
        (req && !wb_we_i && cgms_hit(wb_adr_i, OFF_STATUS))
        |=> wb_dat_o[ST_OSC] == $past(osc_ready_flag))
        else $error("oscillator flag read wrong");

    a_flag_needs_osc: assert property (@(posedge clk) disable iff (!nrst) // R6
        !osc_enable |-> !osc_ready_flag)
        else $error("oscillator flag set while oscillator off");

    a_no_rsvd_status: assert property (@(posedge clk) disable iff (!nrst) // R12
        generator_source != SRC_RSVD)
        else $error("clock status shows reserved code");

    a_status_hold: assert property (@(posedge clk) disable iff (!nrst) // R19
        st.switch_cnt != SWITCH_LAST |=> $stable(st.ref_status) && $stable(generator_source))
        else $error("status changed without full switch time");

    a_low_power_cause: assert property (@(posedge clk) disable iff (!nrst) // R13
        mode == low_power_bypass_mode
        |-> generator_source == SRC_EXT && st.ctrl_two[C2_LOW_POWER])
        else $error("low-power bypass without external source");

    a_switch_count_max: assert property (@(posedge clk) disable iff (!nrst) // R19
        st.switch_cnt <= SWITCH_LAST)
        else $error("switch counter past its end");

endmodule : cgms_top

// File: tb/cgms_xtal.sv
/*
 Crystal model at the far side of the clock generator mode sequencer.
 Assumes the enable and crystal select outputs of cgms_top.
*/
`timescale 1ns/1ps
module cgms_xtal #(
    parameter int START = 20
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic osc_enable,
    input wire logic osc_crystal_sel,
    output logic osc_stable
);
    logic [7:0] count;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            count <= 8'h00;
        else if (!osc_enable)
            count <= 8'h00;
        else if (count != 8'hFF)
            count <= count + 8'h01;
    end
    // Crystal starts slower than a driven clock
    assign osc_stable = osc_enable && (count >= (osc_crystal_sel ? 8'(START) : 8'h02));
endmodule : cgms_xtal

// File: tb/cgms_top_test.sv
/*
 Self-checking bench of the clock generator mode sequencer.
 Assumes cgms_top, the cgms_pkg constants and the crystal model.
*/
`timescale 1ns/1ps
module cgms_top_test;
    import cgms_pkg::*;
    typedef struct {logic [7:0] exp; bit care; string name;} cgms_note_t;
    localparam logic [7:0] c1_tab [4] = '{8'h44, 8'h04, 8'hF8, 8'hB8};
    localparam logic [7:0] st_tab [4] = '{8'h16, 8'h12, 8'h02, 8'h0A};
    localparam logic [7:0] md_tab [4] = '{8'(internal_bypass_mode), 8'(internal_ref_locked_mode),
        8'(external_ref_locked_mode), 8'(low_power_bypass_mode)};
    logic clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, osc_stable, osc_enable;
    logic osc_high_range, osc_high_gain, osc_crystal_sel, osc_ready_flag;
    logic fll_enable, pll_enable;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [1:0] output_divider, generator_source;
    logic [2:0] reference_divider;
    cgms_mode_t mode;
    cgms_note_t notes [$];
    cgms_note_t note;
    int miscompares = 0;
    int comparisons = 0;
    int seed;
    logic [7:0] rnd;
    cgms_top u_cgms_top (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .osc_stable(osc_stable),
        .osc_enable(osc_enable), .osc_high_range(osc_high_range),
        .osc_high_gain(osc_high_gain), .osc_crystal_sel(osc_crystal_sel),
        .osc_ready_flag(osc_ready_flag), .output_divider(output_divider),
        .reference_divider(reference_divider), .generator_source(generator_source),
        .fll_enable(fll_enable), .pll_enable(pll_enable), .mode(mode));
    cgms_xtal u_cgms_xtal (.clk(clk), .nrst(nrst), .osc_enable(osc_enable),
        .osc_crystal_sel(osc_crystal_sel), .osc_stable(osc_stable));
    // ---------------------------------------------------------------
    // Checking tasks
    // ---------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic print_verdict();
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    // ---------------------------------------------------------------
    // Bus tasks
    // ---------------------------------------------------------------
    task automatic bus(input logic we, input logic [3:0] adr, input logic [7:0] dat,
                       input logic [3:0] sel, output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h0, dat};
        @(posedge clk);
        while (wb_ack_o !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge clk);
        end
        if (n == 50)
            chk("ack", 8'h01, 8'h00);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic wr(input logic [3:0] adr, input logic [7:0] dat, input logic [3:0] sel);
        logic [7:0] d;
        bus(1'b1, adr, dat, sel, d);
    endtask : wr
    task automatic rd(input logic [3:0] adr, input logic [7:0] exp, input string name,
                      input bit care, output logic [7:0] d);
        notes.push_back('{exp, care, name});
        bus(1'b0, adr, 8'h00, 4'hF, d);
    endtask : rd
    task automatic rdc(input logic [3:0] adr, input logic [7:0] exp, input string name);
        logic [7:0] d;
        rd(adr, exp, name, 1'b1, d);
    endtask : rdc
    task automatic poll(input logic [7:0] exp);
        logic [7:0] d;
        int n;
        n = 0;
        d = 8'h00;
        while (d !== exp && n < 40)
        begin
            rd(OFF_STATUS, exp, "status", 1'b0, d);
            n++;
        end
        rdc(OFF_STATUS, exp, "status");
    endtask : poll
    // ---------------------------------------------------------------
    // Read data monitor
    // ---------------------------------------------------------------
    always @(posedge clk)
    begin
        if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i && notes.size() > 0)
        begin
            note = notes.pop_front();
            if (note.care)
                chk(note.name, note.exp, wb_dat_o[7:0]);
        end
    end
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        #(20000 * 100);
        miscompares++;
        $display("ERROR watchdog expected done seen hang");
        print_verdict();
    end
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        seed = 41684;
        nrst = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 4'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rdc(OFF_CTRL_ONE, RST_CTRL_ONE, "ctrl_one");
        rdc(OFF_CTRL_TWO, RST_CTRL_TWO, "ctrl_two");
        rdc(OFF_STATUS, 8'h10, "status");
        chk("mode", 8'(internal_ref_locked_mode), 8'(mode));
        chk("fll_enable", 8'h01, 8'(fll_enable));
        chk("pll_enable", 8'h00, 8'(pll_enable));
        rdc(4'hC, 8'h00, "unmapped");
        wr(OFF_STATUS, 8'hFF, 4'hF);
        rdc(OFF_STATUS, 8'h10, "status");
        wr(OFF_CTRL_ONE, 8'hB8, 4'h0);
        rdc(OFF_CTRL_ONE, 8'h04, "ctrl_one");
        rnd = 8'($random(seed)) & 8'hF7;
        wr(OFF_CTRL_TWO, rnd, 4'h1);
        rdc(OFF_CTRL_TWO, rnd, "ctrl_two");
        chk("output_divider", 8'(rnd[7:6]), 8'(output_divider));
        chk("osc_high_range", 8'(rnd[5]), 8'(osc_high_range));
        chk("osc_high_gain", 8'(rnd[4]), 8'(osc_high_gain));
        chk("osc_crystal_sel", 8'(rnd[2]), 8'(osc_crystal_sel));
        chk("osc_enable", 8'(rnd[1]), 8'(osc_enable));
        wr(OFF_CTRL_TWO, 8'h36, 4'h1);
        poll(8'h12);
        chk("osc_ready_flag", 8'h01, 8'(osc_ready_flag));
        wr(OFF_CTRL_ONE, 8'hB8, 4'h1);
        rdc(OFF_STATUS, 8'h12, "status");
        poll(8'h0A);
        chk("mode", 8'(external_bypass_mode), 8'(mode));
        chk("generator_source", 8'h02, 8'(generator_source));
        chk("reference_divider", 8'h07, 8'(reference_divider));
        wr(OFF_CTRL_TWO, 8'h3E, 4'h1);
        chk("mode", 8'(low_power_bypass_mode), 8'(mode));
        chk("fll_enable", 8'h00, 8'(fll_enable));
        chk("output_divider", 8'h00, 8'(output_divider));
        for (int i = 0; i < 4; i++)
        begin
            wr(OFF_CTRL_ONE, c1_tab[i], 4'h1);
            repeat (12) @(posedge clk);
            rdc(OFF_STATUS, st_tab[i], "status");
            chk("mode", md_tab[i], 8'(mode));
            chk("fll_enable", (i == 3) ? 8'h00 : 8'h01, 8'(fll_enable));
        end
        print_verdict();
    end
endmodule : cgms_top_test
